/* File: verilog/status_cmd_defs.svh */
// constants for the system and status command block
`ifndef STATUS_CMD_DEFS_SVH
`define STATUS_CMD_DEFS_SVH

// ----------------------------------------------------------------
// event register and enable mask layout
// ----------------------------------------------------------------
`define MASK_RESET 8'h80
`define ESR_RESET 8'h80
`define ESR_USED_MASK 8'hBC
`define BIT_POWER_ON 7
`define BIT_COMMAND 5
`define BIT_EXECUTION 4
`define BIT_DEVICE 3
`define BIT_QUERY 2
`define STB_SUMMARY_BIT 5

// ----------------------------------------------------------------
// error queue
// ----------------------------------------------------------------
`define ERRQ_DEPTH 16
`define ERRQ_AW 4
`define ERRQ_CW 5
`define ERRQ_FULL 5'h10
`define ERR_CODE_NONE 16'h0000
`define ERR_CODE_TOO_MANY 16'hFEA2
`define ERR_MSG_NONE 8'h00
`define ERR_MSG_TOO_MANY 8'h01

// ----------------------------------------------------------------
// command fields and settings
// ----------------------------------------------------------------
`define LEAD_STAR 8'h2A
`define SLOT_MAX 4'h8
`define SLOT_FACTORY 4'h8
`define DISP_FREQ 1'b0
`define DISP_CURRENT 1'b1
`define VOLT_CEILING 16'h0110

`endif

/* File: verilog/status_cmd_pkg.sv */
// types shared by the system and status command block
`include "status_cmd_defs.svh"

package status_cmd_pkg;

	typedef enum logic [3:0] {
		OP_CLS,
		OP_MASK,
		OP_ESR,
		OP_STB,
		OP_ERR,
		OP_KLOCK,
		OP_LOCAL,
		OP_REMOTE,
		OP_SLOT,
		OP_DISP,
		OP_VOLT_CEIL,
		OP_OTHER
	} cmd_op_t;

	typedef struct packed {
		logic [7:0] lead;
		logic query;
		cmd_op_t op;
		logic [15:0] arg;
	} cmd_t;

	typedef struct packed {
		logic [15:0] code;
		logic [7:0] msg;
	} err_entry_t;

	typedef struct packed {
		logic command_fault;
		logic execution_fault;
		logic device_specific_fault;
		logic query_fault;
	} fault_t;

endpackage

/* File: verilog/status_cmd.sv */
// system and status command interpreter: error queue, remote/local, event status
//
// Behaviour
// [RQ1] ceiling query answers max high-range voltage; set refused
// [RQ2] display selector: 0 frequency, 1 current; queryable
// [RQ3] errors appended to fifo with number and message
// [RQ4] error read returns oldest entry and removes it
// [RQ5] empty queue read returns 0, no error
// [RQ6] overflow makes last entry too-many-errors code
// [RQ7] lock setting 1 powers up remote, 0 local
// [RQ8] locked out: only bus command leaves remote
// [RQ9] writing lock setting leaves present state alone
// [RQ10] serial local/remote commands set panel state
// [RQ11] on bus interface REN decides remote/local
// [RQ12] slot 0..8; 8 or invalid uses factory defaults
// [RQ13] clear status clears events, status byte, queue
// [RQ14] enabled events ORed into event summary bit
// [RQ15] enable mask 0..255, 128 at power-on, queryable
// [RQ16] mask and events share one bit layout
// [RQ17] common commands start with asterisk
// [RQ18] event register read returns and clears it
// [RQ19] eight stored states, slots the selector names
// [RQ20] queue depth sixteen, marker in last slot
`timescale 1ns/100ps
`include "status_cmd_defs.svh"

module status_cmd (
	input wire logic mclk, // system clock, 100 MHz
	input wire logic rst, // power-up reset, async, active high
	input wire logic cmd_valid, // decoded command present
	input status_cmd_pkg::cmd_t cmd, // decoded command
	input wire logic err_valid, // programming error occurred
	input status_cmd_pkg::err_entry_t err_in, // error number and message id
	input status_cmd_pkg::fault_t fault_in, // event pulses from elsewhere
	input wire logic bus_if_sel, // 1 IEEE 488 link, 0 serial link
	input wire logic ren, // remote enable line of the 488 link
	input wire logic panel_local_req, // front panel local key
	input wire logic nv_klock, // stored power-up lock setting
	input wire logic [3:0] nv_slot, // stored power-up slot
	input wire logic slot_data_valid, // selected slot holds valid data
	output logic rsp_valid, // answer pulse
	output status_cmd_pkg::err_entry_t rsp, // answer value and message id
	output logic remote, // remote state, panel disabled
	output logic lockout, // keyboard lockout in effect
	output logic disp_mode, // 0 frequency, 1 current shown
	output logic [7:0] status_byte, // status byte, summary bit only
	output logic nv_klock_wr, // store new lock setting pulse
	output logic nv_klock_data, // lock setting to store
	output logic [3:0] slot_sel, // power-up slot selector
	output logic init_factory // initialise from factory defaults
);
	import status_cmd_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic boot_reg;
	logic klock_reg;
	logic [3:0] slot_reg;
	logic disp_reg;
	logic [7:0] event_enable_mask_reg;
	logic [7:0] esr_reg;
	logic [7:0] stb_reg;
	logic remote_reg;
	logic lockout_reg;
	logic rsp_valid_reg;
	err_entry_t rsp_reg;
	logic nv_wr_reg;
	logic init_factory_reg;
	err_entry_t err_mem [`ERRQ_DEPTH];
	logic [`ERRQ_AW-1:0] wr_ptr_reg;
	logic [`ERRQ_AW-1:0] rd_ptr_reg;
	logic [`ERRQ_CW-1:0] cnt_reg;

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	logic is_common;
	logic fmt_ok;
	logic go;
	logic do_cls, do_mask_wr, do_esr_rd, do_err_rd, do_kl_wr, do_loc, do_rem;
	logic do_slot_wr, do_disp_wr;
	logic bad_cmd, bad_exec, bad_query;
	logic rsp_valid_next;
	err_entry_t rsp_next;
	err_entry_t head;
	logic pop, push, room;
	logic [7:0] esr_set;

	assign head = (cnt_reg != '0) ? err_mem[rd_ptr_reg] : {`ERR_CODE_NONE, `ERR_MSG_NONE}; // RQ5
	assign is_common = (cmd.op == OP_CLS) || (cmd.op == OP_MASK) ||
		(cmd.op == OP_ESR) || (cmd.op == OP_STB);
	assign fmt_ok = is_common == (cmd.lead == `LEAD_STAR); // RQ17

	always_comb begin
		go = cmd_valid && fmt_ok;
		do_cls = 1'b0;
		do_mask_wr = 1'b0;
		do_esr_rd = 1'b0;
		do_err_rd = 1'b0;
		do_kl_wr = 1'b0;
		do_loc = 1'b0;
		do_rem = 1'b0;
		do_slot_wr = 1'b0;
		do_disp_wr = 1'b0;
		bad_cmd = cmd_valid && !fmt_ok;
		bad_exec = 1'b0;
		bad_query = 1'b0;
		rsp_valid_next = 1'b0;
		rsp_next = {`ERR_CODE_NONE, `ERR_MSG_NONE};
		if (go) begin
			case (cmd.op)
				OP_CLS: begin
					bad_query = cmd.query;
					do_cls = !cmd.query; // RQ13
				end
				OP_MASK: begin
					if (cmd.query) begin
						rsp_valid_next = 1'b1; // RQ15
						rsp_next.code = {8'h00, event_enable_mask_reg};
					end else if (cmd.arg[15:8] != 8'h00) begin
						bad_exec = 1'b1;
					end else begin
						do_mask_wr = 1'b1; // RQ15
					end
				end
				OP_ESR: begin
					bad_cmd = !cmd.query;
					do_esr_rd = cmd.query; // RQ18
					rsp_valid_next = cmd.query;
					rsp_next.code = {8'h00, esr_reg};
				end
				OP_STB: begin
					bad_cmd = !cmd.query;
					rsp_valid_next = cmd.query;
					rsp_next.code = {8'h00, stb_reg};
				end
				OP_ERR: begin
					bad_cmd = !cmd.query;
					do_err_rd = cmd.query; // RQ4
					rsp_valid_next = cmd.query;
					rsp_next = head;
				end
				OP_KLOCK: begin
					if (cmd.query) begin
						rsp_valid_next = 1'b1;
						rsp_next.code = {15'h0000, klock_reg};
					end else if (cmd.arg > 16'h0001) begin
						bad_exec = 1'b1;
					end else begin
						do_kl_wr = 1'b1;
					end
				end
				OP_LOCAL: begin
					bad_query = cmd.query;
					do_loc = !cmd.query;
				end
				OP_REMOTE: begin
					bad_query = cmd.query;
					do_rem = !cmd.query;
				end
				OP_SLOT: begin
					if (cmd.query) begin
						rsp_valid_next = 1'b1;
						rsp_next.code = {12'h000, slot_reg};
					end else if (cmd.arg > {12'h000, `SLOT_MAX}) begin
						bad_exec = 1'b1; // RQ12
					end else begin
						do_slot_wr = 1'b1;
					end
				end
				OP_DISP: begin
					if (cmd.query) begin
						rsp_valid_next = 1'b1; // RQ2
						rsp_next.code = {15'h0000, disp_reg};
					end else if (cmd.arg > 16'h0001) begin
						bad_exec = 1'b1;
					end else begin
						do_disp_wr = 1'b1;
					end
				end
				OP_VOLT_CEIL: begin
					// ceiling is factory set; a write is refused, not applied
					bad_exec = !cmd.query; // RQ1
					rsp_valid_next = cmd.query;
					rsp_next.code = `VOLT_CEILING; // RQ1
				end
				default: begin
					bad_cmd = 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// error queue
	// ----------------------------------------------------------------
	assign pop = do_err_rd && (cnt_reg != '0);
	assign push = err_valid;
	assign room = (cnt_reg != `ERRQ_FULL) || pop;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			cnt_reg <= '0;
		end else if (do_cls) begin
			// an error arriving with the clear survives it
			rd_ptr_reg <= '0; // RQ13
			wr_ptr_reg <= {{(`ERRQ_AW-1){1'b0}}, push};
			cnt_reg <= {{(`ERRQ_CW-1){1'b0}}, push};
		end else begin
			if (push && room) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1; // RQ3
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1; // RQ4
			end
			if ((push && room) && !pop) begin
				cnt_reg <= cnt_reg + 1'b1;
			end else if (pop && !(push && room)) begin
				cnt_reg <= cnt_reg - 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (push && do_cls) begin
			err_mem[0] <= err_in;
		end else if (push && room) begin
			err_mem[wr_ptr_reg] <= err_in; // RQ3
		end else if (push) begin
			// full: newest slot turns into the overflow marker
			err_mem[wr_ptr_reg - 1'b1] <= {`ERR_CODE_TOO_MANY, `ERR_MSG_TOO_MANY}; // RQ6 RQ20
		end
	end

	// ----------------------------------------------------------------
	// event register, enable mask, status byte
	// ----------------------------------------------------------------
	always_comb begin
		esr_set = 8'h00;
		esr_set[`BIT_COMMAND] = bad_cmd || fault_in.command_fault; // RQ16
		esr_set[`BIT_EXECUTION] = bad_exec || fault_in.execution_fault;
		esr_set[`BIT_DEVICE] = fault_in.device_specific_fault;
		esr_set[`BIT_QUERY] = bad_query || fault_in.query_fault;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			esr_reg <= `ESR_RESET;
		end else if (do_cls || do_esr_rd) begin
			esr_reg <= esr_set & `ESR_USED_MASK; // RQ18 RQ13
		end else begin
			esr_reg <= esr_reg | (esr_set & `ESR_USED_MASK);
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			event_enable_mask_reg <= `MASK_RESET; // RQ15
		end else if (do_mask_wr) begin
			event_enable_mask_reg <= cmd.arg[7:0]; // RQ15
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			stb_reg <= 8'h00;
		end else if (do_cls) begin
			stb_reg <= 8'h00; // RQ13
		end else begin
			stb_reg <= 8'h00;
			stb_reg[`STB_SUMMARY_BIT] <= |(esr_reg & event_enable_mask_reg); // RQ14
		end
	end

	// ----------------------------------------------------------------
	// power-up settings, remote/local state
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			boot_reg <= 1'b0;
			klock_reg <= 1'b0;
			slot_reg <= `SLOT_FACTORY;
			nv_wr_reg <= 1'b0;
		end else begin
			boot_reg <= 1'b1;
			nv_wr_reg <= do_kl_wr;
			if (!boot_reg) begin
				klock_reg <= nv_klock;
				slot_reg <= nv_slot; // RQ19
			end else begin
				if (do_kl_wr) begin
					klock_reg <= cmd.arg[0]; // RQ9
				end
				if (do_slot_wr) begin
					slot_reg <= cmd.arg[3:0];
				end
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			init_factory_reg <= 1'b1;
		end else begin
			init_factory_reg <= (slot_reg == `SLOT_FACTORY) || !slot_data_valid; // RQ12
		end
	end

	// the stored lock setting is read only at boot, never on a write
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			remote_reg <= 1'b0;
			lockout_reg <= 1'b0;
		end else if (!boot_reg) begin
			remote_reg <= nv_klock; // RQ7
			lockout_reg <= nv_klock; // RQ7
		end else if (bus_if_sel) begin
			remote_reg <= ren; // RQ11
			if (!ren) begin
				lockout_reg <= 1'b0; // RQ8
			end
		end else if (do_loc) begin
			remote_reg <= 1'b0; // RQ10 RQ8
			lockout_reg <= 1'b0;
		end else if (do_rem) begin
			remote_reg <= 1'b1; // RQ10
		end else if (panel_local_req && !lockout_reg) begin
			remote_reg <= 1'b0; // RQ8
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			disp_reg <= `DISP_FREQ;
		end else if (do_disp_wr) begin
			disp_reg <= cmd.arg[0]; // RQ2
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rsp_valid_reg <= 1'b0;
			rsp_reg <= {`ERR_CODE_NONE, `ERR_MSG_NONE};
		end else begin
			rsp_valid_reg <= rsp_valid_next;
			if (rsp_valid_next) begin
				rsp_reg <= rsp_next;
			end
		end
	end

	assign rsp_valid = rsp_valid_reg;
	assign rsp = rsp_reg;
	assign remote = remote_reg;
	assign lockout = lockout_reg;
	assign disp_mode = disp_reg;
	assign status_byte = stb_reg;
	assign nv_klock_wr = nv_wr_reg;
	assign nv_klock_data = klock_reg;
	assign slot_sel = slot_reg;
	assign init_factory = init_factory_reg;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	property p_ceil_query;
		go && cmd.op == OP_VOLT_CEIL && cmd.query |=> rsp_valid && rsp.code == `VOLT_CEILING;
	endproperty
	a_ceil_query: assert property (p_ceil_query) else $error("ceiling query bad answer"); // RQ1

	property p_disp_query;
		go && cmd.op == OP_DISP && cmd.query |=> rsp_valid && rsp.code[0] == $past(disp_reg);
	endproperty
	a_disp_query: assert property (p_disp_query) else $error("display query mismatch"); // RQ2

	property p_err_pop;
		pop && !push && !do_cls |=> cnt_reg == $past(cnt_reg) - 1'b1;
	endproperty
	a_err_pop: assert property (p_err_pop) else $error("error read did not remove entry"); // RQ4

	property p_err_empty;
		do_err_rd && cnt_reg == '0 && !push |=> rsp.code == `ERR_CODE_NONE && cnt_reg == '0;
	endproperty
	a_err_empty: assert property (p_err_empty) else $error("empty queue read not zero"); // RQ5

	property p_err_overflow;
		push && !room && !do_cls |=> cnt_reg == `ERRQ_FULL &&
			err_mem[wr_ptr_reg - 1'b1].code == `ERR_CODE_TOO_MANY;
	endproperty
	a_err_overflow: assert property (p_err_overflow) else $error("overflow marker missing"); // RQ6

	property p_klock_keeps_state;
		boot_reg && do_kl_wr && !bus_if_sel && !panel_local_req |=> $stable(remote_reg);
	endproperty
	a_klock_keeps_state: assert property (p_klock_keeps_state) else $error("state moved"); // RQ9

	property p_ren_follow;
		boot_reg && bus_if_sel ##1 bus_if_sel [*2] |-> remote_reg == $past(ren);
	endproperty
	a_ren_follow: assert property (p_ren_follow) else $error("remote not following REN"); // RQ11

	// the edge that leaves reset still loads the reset value, so skip it
	property p_summary;
		!$past(do_cls) && !$past(rst) |-> status_byte[`STB_SUMMARY_BIT] ==
			$past(|(esr_reg & event_enable_mask_reg));
	endproperty
	a_summary: assert property (p_summary) else $error("summary bit wrong"); // RQ14

	property p_mask_write;
		do_mask_wr |=> event_enable_mask_reg == $past(cmd.arg[7:0]) && !rsp_valid;
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("enable mask not stored"); // RQ15

	property p_esr_read;
		do_esr_rd && esr_set == 8'h00 |=> esr_reg == 8'h00 && rsp.code[7:0] == $past(esr_reg);
	endproperty
	a_esr_read: assert property (p_esr_read) else $error("event read did not clear"); // RQ18

	property p_cls;
		do_cls && !push |=> cnt_reg == '0 && status_byte == 8'h00 && esr_reg == $past(esr_set);
	endproperty
	a_cls: assert property (p_cls) else $error("clear status incomplete"); // RQ13

	c_overflow: cover property (push && !room);
	c_err_read: cover property (pop ##1 rsp_valid);
	c_summary_set: cover property (status_byte[`STB_SUMMARY_BIT]);
	c_lock_boot: cover property (!boot_reg ##1 lockout_reg);

endmodule // status_cmd

/* File: bench/host_model.sv */
// host controller model: issues decoded commands and drives the remote enable line
`timescale 1ns/100ps
`include "status_cmd_defs.svh"

module host_model (
	input wire logic mclk, // system clock
	output logic cmd_valid, // command strobe
	output status_cmd_pkg::cmd_t cmd, // command word
	output logic ren, // remote enable line level
	input wire logic rsp_valid, // answer strobe
	input status_cmd_pkg::err_entry_t rsp // answer value
);
	import status_cmd_pkg::*;

	logic bad_lead;

	initial begin
		cmd_valid = 1'b0;
		cmd = '0;
		ren = 1'b0;
		bad_lead = 1'b0;
	end

	// ------------------------------------------------------------
	// command issue
	// ------------------------------------------------------------
	task automatic send(input cmd_op_t op, input logic q, input logic [15:0] a);
		logic common;
		common = op inside {OP_CLS, OP_MASK, OP_ESR, OP_STB};
		@(posedge mclk);
		cmd_valid <= 1'b1;
		cmd <= '{lead: (common ^ bad_lead) ? `LEAD_STAR : 8'h53, query: q, op: op, arg: a};
		@(posedge mclk);
		cmd_valid <= 1'b0;
		// released word is inverted so a stale command is never mistaken for a live one
		cmd <= ~cmd;
		#1;
	endtask

	task automatic ask(input cmd_op_t op, output logic got, output err_entry_t r);
		send(op, 1'b1, 16'h0000);
		got = rsp_valid;
		r = rsp;
	endtask

	task automatic drive_ren(input logic v);
		@(posedge mclk);
		ren <= v;
	endtask
endmodule // host_model

/* File: bench/tb.sv */
// self-checking bench for the system and status command block
`timescale 1ns/100ps
`include "status_cmd_defs.svh"
`define CHK(a, e, m) begin n_compared++; if ((a) !== (e)) begin num_errors++; \
	$display("wrong value at %0t: %s", $time, m); end end

module tb;
	import status_cmd_pkg::*;

	logic mclk, rst, cmd_valid, err_valid, bus_if_sel, ren, panel_local_req;
	logic nv_klock, slot_data_valid, rsp_valid, remote, lockout, disp_mode;
	logic nv_klock_wr, nv_klock_data, init_factory;
	logic [3:0] nv_slot;
	logic [3:0] slot_sel;
	logic [7:0] status_byte;
	cmd_t cmd;
	err_entry_t err_in;
	err_entry_t rsp;
	fault_t fault_in;
	int num_errors = 0;
	int n_compared = 0;
	int cycles = 0;

	status_cmd status_cmd_inst (.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
		.err_valid(err_valid), .err_in(err_in), .fault_in(fault_in), .bus_if_sel(bus_if_sel),
		.ren(ren), .panel_local_req(panel_local_req), .nv_klock(nv_klock), .nv_slot(nv_slot),
		.slot_data_valid(slot_data_valid), .rsp_valid(rsp_valid), .rsp(rsp), .remote(remote),
		.lockout(lockout), .disp_mode(disp_mode), .status_byte(status_byte),
		.nv_klock_wr(nv_klock_wr), .nv_klock_data(nv_klock_data), .slot_sel(slot_sel),
		.init_factory(init_factory));

	host_model host_model_inst (.mclk(mclk), .cmd_valid(cmd_valid), .cmd(cmd), .ren(ren),
		.rsp_valid(rsp_valid), .rsp(rsp));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic summarize();
		$display("compared %0d, wrong %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// run is about 200 cycles; the ceiling leaves ample margin
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			summarize();
		end
	end

	task automatic wait_n(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic do_reset(input logic klock, input logic [3:0] slot);
		@(posedge mclk);
		rst <= 1'b1;
		nv_klock <= klock;
		nv_slot <= slot;
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		wait_n(3);
	endtask

	task automatic expect_q(input cmd_op_t op, input logic [15:0] code, input logic [7:0] msg,
		input string m);
		logic got;
		err_entry_t r;
		host_model_inst.ask(op, got, r);
		`CHK({got, r}, {1'b1, code, msg}, m)
	endtask

	task automatic push_n(input int n, input logic [15:0] base);
		for (int i = 0; i < n; i++) begin
			@(posedge mclk);
			err_valid <= 1'b1;
			err_in <= '{code: base + 16'(i), msg: 8'(i)};
		end
		@(posedge mclk);
		err_valid <= 1'b0;
		#1;
	endtask

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		rst = 1'b1;
		err_valid = 1'b0;
		err_in = '0;
		fault_in = '0;
		bus_if_sel = 1'b0;
		panel_local_req = 1'b0;
		nv_klock = 1'b1;
		nv_slot = 4'h3;
		slot_data_valid = 1'b1;
		do_reset(1'b1, 4'h3);
		`CHK({remote, lockout, slot_sel}, {2'b11, 4'h3}, "locked powerup")
		`CHK(status_byte, 8'h20, "summary at powerup")
		expect_q(OP_MASK, 16'h0080, 8'h00, "mask reset");
		expect_q(OP_ESR, 16'h0080, 8'h00, "event reset");
		expect_q(OP_ESR, 16'h0000, 8'h00, "event cleared");
		wait_n(1);
		`CHK(status_byte, 8'h00, "summary cleared")
		$display("test powerup done");

		@(posedge mclk) panel_local_req <= 1'b1;
		wait_n(3);
		`CHK(remote, 1'b1, "panel refused while locked")
		host_model_inst.send(OP_LOCAL, 1'b0, 16'h0000);
		`CHK({remote, lockout}, 2'b00, "local command")
		@(posedge mclk) panel_local_req <= 1'b0;
		host_model_inst.send(OP_REMOTE, 1'b0, 16'h0000);
		`CHK({remote, lockout}, 2'b10, "remote command")
		@(posedge mclk) panel_local_req <= 1'b1;
		wait_n(2);
		`CHK(remote, 1'b0, "panel local")
		@(posedge mclk) panel_local_req <= 1'b0;
		host_model_inst.send(OP_REMOTE, 1'b0, 16'h0000);
		host_model_inst.send(OP_KLOCK, 1'b0, 16'h0000);
		`CHK({nv_klock_wr, nv_klock_data, remote}, 3'b101, "lock write")
		expect_q(OP_KLOCK, 16'h0000, 8'h00, "lock query");
		$display("test remote local done");

		do_reset(1'b0, 4'h8);
		`CHK({remote, lockout, slot_sel, init_factory}, 7'b0010001, "local powerup")
		host_model_inst.send(OP_SLOT, 1'b0, 16'h0007);
		wait_n(1);
		`CHK({slot_sel, init_factory}, {4'h7, 1'b0}, "slot 7")
		@(posedge mclk) slot_data_valid <= 1'b0;
		wait_n(2);
		`CHK(init_factory, 1'b1, "invalid slot data")
		@(posedge mclk) slot_data_valid <= 1'b1;
		host_model_inst.send(OP_SLOT, 1'b0, 16'h0009);
		expect_q(OP_SLOT, 16'h0007, 8'h00, "slot range");
		expect_q(OP_ESR, 16'h0090, 8'h00, "slot refused");
		for (int d = 1; d >= 0; d--) begin
			host_model_inst.send(OP_DISP, 1'b0, 16'(d));
			`CHK(disp_mode, 1'(d), "display select")
			expect_q(OP_DISP, 16'(d), 8'h00, "display query");
		end
		expect_q(OP_VOLT_CEIL, `VOLT_CEILING, 8'h00, "ceiling");
		host_model_inst.send(OP_VOLT_CEIL, 1'b0, 16'h0001);
		expect_q(OP_VOLT_CEIL, `VOLT_CEILING, 8'h00, "ceiling kept");
		expect_q(OP_ESR, 16'h0010, 8'h00, "ceiling set refused");
		$display("test settings done");

		host_model_inst.send(OP_MASK, 1'b0, 16'h0020);
		host_model_inst.send(OP_MASK, 1'b0, 16'h0100);
		expect_q(OP_MASK, 16'h0020, 8'h00, "mask range");
		`CHK(status_byte, 8'h00, "masked event")
		@(posedge mclk) fault_in <= 4'b1111;
		@(posedge mclk) fault_in <= 4'b0000;
		wait_n(2);
		`CHK(status_byte, 8'h20, "enabled event")
		expect_q(OP_ESR, 16'h003C, 8'h00, "event layout");
		host_model_inst.bad_lead = 1'b1;
		host_model_inst.send(OP_MASK, 1'b0, 16'h00FF);
		host_model_inst.bad_lead = 1'b0;
		expect_q(OP_ESR, 16'h0020, 8'h00, "format fault");
		expect_q(OP_MASK, 16'h0020, 8'h00, "mask kept");
		$display("test events done");

		expect_q(OP_ERR, `ERR_CODE_NONE, `ERR_MSG_NONE, "empty queue");
		push_n(3, 16'hFF9C);
		for (int i = 0; i < 3; i++)
			expect_q(OP_ERR, 16'hFF9C + 16'(i), 8'(i), "fifo order");
		push_n(18, 16'hFF00);
		for (int i = 0; i < 16; i++)
			expect_q(OP_ERR, (i < 15) ? 16'hFF00 + 16'(i) : `ERR_CODE_TOO_MANY,
				(i < 15) ? 8'(i) : `ERR_MSG_TOO_MANY, "overflow");
		expect_q(OP_ERR, `ERR_CODE_NONE, `ERR_MSG_NONE, "drained");
		push_n(2, 16'hFF90);
		@(posedge mclk) fault_in <= 4'b1000;
		@(posedge mclk) fault_in <= 4'b0000;
		host_model_inst.send(OP_CLS, 1'b0, 16'h0000);
		`CHK(status_byte, 8'h00, "clear summary")
		expect_q(OP_ERR, `ERR_CODE_NONE, `ERR_MSG_NONE, "clear queue");
		expect_q(OP_ESR, 16'h0000, 8'h00, "clear events");
		$display("test error queue done");

		@(posedge mclk) bus_if_sel <= 1'b1;
		host_model_inst.drive_ren(1'b1);
		wait_n(2);
		`CHK(remote, 1'b1, "ren high")
		host_model_inst.send(OP_LOCAL, 1'b0, 16'h0000);
		wait_n(1);
		`CHK(remote, 1'b1, "local ignored on bus")
		host_model_inst.drive_ren(1'b0);
		wait_n(2);
		`CHK({remote, lockout}, 2'b00, "ren low")
		$display("test bus link done");
		summarize();
	end
endmodule // tb
